//--- hw/ssf_pkg.sv
package ssf_pkg;
   // ----------------------------------------
   // frame layout
   // ----------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int WR_BIT = 15;
   localparam int PAR_BIT = 15;
   localparam int PTR_HI = 14;
   localparam int PTR_LO = 12;
   localparam int PAY_HI = 11;
   localparam int PAY_LO = 0;
   localparam int PTR_W = 3;
   localparam int PAY_W = 12;
   localparam int REG_COUNT = 8;
   localparam int MOD_W = 3;
   localparam logic [PTR_W-1:0] SDS_PTR = 3'h0;
   localparam logic [PAY_W-1:0] REG_RESET = 12'h000;
   localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;
   // ----------------------------------------
   // host registers
   // ----------------------------------------
   localparam int APB_AW = 4;
   localparam int APB_DW = 32;
   localparam logic [APB_AW-1:0] CMD_OFS = 4'h0;
   localparam logic [APB_AW-1:0] RSP_OFS = 4'h4;
   localparam logic [APB_AW-1:0] STAT_OFS = 4'h8;
   localparam int BUSY_POS = 0;
   localparam int NEW_POS = 1;
   localparam logic [APB_DW-1:0] BUS_RESET = 32'h00000000;
   // ----------------------------------------
   // daisy chain
   // ----------------------------------------
   localparam int CHAIN_DEVICES = 1;
   localparam int CHAIN_BITS = FRAME_BITS * CHAIN_DEVICES;
   localparam int BITCNT_W = 8;
   localparam logic [BITCNT_W-1:0] BITS_TOTAL = 8'(CHAIN_BITS);
   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   localparam int SEL_IDX = 0;
   localparam int CLK_IDX = 1;
   localparam int DIN_IDX = 2;
   localparam logic [2:0] SYNC_RESET = 3'h1;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int SCLK_PERIOD_NS = 200;
   localparam int LEAD_NS = 250;
   localparam int LAG_NS = 250;
   localparam int GAP_NS = 250;
   localparam int HALF_CYC = (SCLK_PERIOD_NS * CLK_MHZ + 1999) / 2000;
   localparam int LEAD_CYC = (LEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int LAG_CYC = (LAG_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W = 8;
   localparam logic [TMR_W-1:0] HALF_LAST = 8'(HALF_CYC - 1);
   localparam logic [TMR_W-1:0] LEAD_LAST = 8'(LEAD_CYC - 1);
   localparam logic [TMR_W-1:0] LAG_LAST = 8'(LAG_CYC - 1);
   localparam logic [TMR_W-1:0] GAP_LAST = 8'(GAP_CYC - 1);
   // ----------------------------------------
   // master states
   // ----------------------------------------
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LEAD = 3'b001,
      H_HIGH = 3'b010,
      H_LOW = 3'b011,
      H_LAG = 3'b100,
      H_GAP = 3'b101
   } ssf_hstate_t;
endpackage

//--- hw/ssf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssf_link_if;
   logic selN;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdoOeN;
   wire sdoLine;
   // a released pin shows the inverse of the last bit
   assign sdoLine = sdoOeN ? ~sdo : sdo;
   modport dev (input selN, input sclk, input sdi, output sdo, output sdoOeN);
   modport host (output selN, output sclk, output sdi, input sdoLine);
endinterface
`default_nettype wire

//--- hw/ssf_dev_end.sv
// Summary of operation
// [R1] shift only while select is low
// [R2] select high: ignore clock, output floats
// [R3] select falling loads response into shifter
// [R4] decode only on nonzero multiple-of-8 clocks
// [R5] sample on clock fall, advance on rise
// [R6] master keeps clock low around select edges
// [R7] both directions most significant bit first
// [R8] output driven with first bit at select fall
// [R9] shifter passes input bits through to output
// [R10] master clocks sixteen bits per chained device
// [R11] frame: write bit, pointer, payload
// [R12] write lands at select rising edge
// [R13] after write, return the written register; a write to pointer 0 returns diagStatus instead
// [R14] after read, return addressed register next frame
// [R15] reply: parity, echoed pointer, data
// [R16] parity set on odd ones count
// [R17] first reply after reset is short diagnosis
// [R18] master reads in two frames
// [R19] bad clock count discards whole frame
// [R20] long frames use last sixteen bits
`timescale 1ns/1ps
`default_nettype none
module ssf_dev_end
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // serial link
   ssf_link_if.dev link,
   // feedback from the switch core
   input wire logic [PAY_W-1:0] diagStatus,
   // register contents
   output logic [REG_COUNT*PAY_W-1:0] regsFlat,
   // write events
   output logic wrStrobe,
   output logic [PTR_W-1:0] wrPtr,
   output logic [PAY_W-1:0] wrData,
   // frame events
   output logic rxValid,
   output logic [FRAME_BITS-1:0] rxFrame,
   output logic frameDrop,
   output logic linkBusy
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pinIn;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] filt_r;
   logic [2:0] filtNxt;

   assign pinIn = {link.sdi, link.sclk, link.selN};

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s1_r <= SYNC_RESET;
         s2_r <= SYNC_RESET;
         s3_r <= SYNC_RESET;
         filt_r <= SYNC_RESET;
      end
      else
      begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filtNxt;
      end
   end

   // a change counts once stages two and three agree
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_filt
         assign filtNxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
      end
   endgenerate

   // ----------------------------------------
   // edge detection
   // ----------------------------------------
   wire active;
   wire selFall;
   wire selRise;
   wire clkFall;
   wire clkRise;
   wire dinBit;

   assign active = ~filt_r[SEL_IDX]; // R1 R2
   assign selFall = filt_r[SEL_IDX] & ~filtNxt[SEL_IDX];
   assign selRise = ~filt_r[SEL_IDX] & filtNxt[SEL_IDX];
   assign clkFall = active & filt_r[CLK_IDX] & ~filtNxt[CLK_IDX]; // R2
   assign clkRise = active & ~filt_r[CLK_IDX] & filtNxt[CLK_IDX]; // R2
   assign dinBit = filtNxt[DIN_IDX];

   // ----------------------------------------
   // register file and response
   // ----------------------------------------
   logic [PAY_W-1:0] regs_r [0:REG_COUNT-1];
   logic [PTR_W-1:0] pendPtr_r;
   logic [FRAME_BITS-1:0] sh_r;
   logic [MOD_W-1:0] cnt_r;
   logic any_r;
   wire [PAY_W-1:0] rdData;
   wire [FRAME_BITS-1:0] resp;
   wire rxWr;
   wire [PTR_W-1:0] rxPtr;
   wire [PAY_W-1:0] rxPay;
   wire frameOk;
   wire decode;
   wire doWrite;

   assign rdData = (pendPtr_r == SDS_PTR) ? diagStatus : regs_r[pendPtr_r]; // R13 R14 R17
   assign resp = {^{pendPtr_r, rdData}, pendPtr_r, rdData}; // R15 R16
   assign rxWr = sh_r[WR_BIT]; // R11 R20
   assign rxPtr = sh_r[PTR_HI:PTR_LO]; // R11
   assign rxPay = sh_r[PAY_HI:PAY_LO]; // R11
   assign frameOk = any_r & (cnt_r == 3'h0); // R4 R19
   assign decode = selRise & frameOk; // R4
   assign doWrite = decode & rxWr; // R12

   generate
      for (genvar e = 0; e < REG_COUNT; e++)
      begin : g_reg
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               regs_r[e] <= REG_RESET;
            end
            else if (doWrite && (rxPtr == PTR_W'(e)))
            begin
               regs_r[e] <= rxPay; // R12
            end
         end
         assign regsFlat[e*PAY_W +: PAY_W] = regs_r[e];
      end
   endgenerate

   // pointer of the reply for the next frame
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pendPtr_r <= SDS_PTR; // R17
      end
      else if (decode)
      begin
         pendPtr_r <= rxPtr; // R13 R14
      end
   end

   // ----------------------------------------
   // shift register and modulo-8 counter
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sh_r <= FRAME_RESET;
         cnt_r <= 3'h0;
         any_r <= 1'b0;
      end
      else if (selFall)
      begin
         sh_r <= resp; // R3
         cnt_r <= 3'h0;
         any_r <= 1'b0;
      end
      else if (clkFall)
      begin
         sh_r <= {sh_r[FRAME_BITS-2:0], dinBit}; // R5 R7 R9
         cnt_r <= cnt_r + 3'h1; // R4
         any_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // serial output
   // ----------------------------------------
   logic sdo_r;
   logic oeN_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sdo_r <= 1'b0;
         oeN_r <= 1'b1;
      end
      else if (selFall)
      begin
         sdo_r <= resp[PAR_BIT]; // R8
         oeN_r <= 1'b0; // R8
      end
      else if (selRise)
      begin
         oeN_r <= 1'b1; // R2
      end
      else if (clkRise)
      begin
         sdo_r <= sh_r[FRAME_BITS-1]; // R5 R7 R9
      end
   end

   assign link.sdo = sdo_r;
   assign link.sdoOeN = oeN_r;

   // ----------------------------------------
   // user-side events
   // ----------------------------------------
   logic wrStrobe_r;
   logic [PTR_W-1:0] wrPtr_r;
   logic [PAY_W-1:0] wrData_r;
   logic rxValid_r;
   logic [FRAME_BITS-1:0] rxFrame_r;
   logic drop_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wrStrobe_r <= 1'b0;
         wrPtr_r <= 3'h0;
         wrData_r <= REG_RESET;
         rxValid_r <= 1'b0;
         rxFrame_r <= FRAME_RESET;
         drop_r <= 1'b0;
      end
      else
      begin
         wrStrobe_r <= doWrite;
         rxValid_r <= decode;
         drop_r <= selRise & ~frameOk; // R19
         if (doWrite)
         begin
            wrPtr_r <= rxPtr;
            wrData_r <= rxPay;
         end
         if (decode)
         begin
            rxFrame_r <= sh_r;
         end
      end
   end

   assign wrStrobe = wrStrobe_r;
   assign wrPtr = wrPtr_r;
   assign wrData = wrData_r;
   assign rxValid = rxValid_r;
   assign rxFrame = rxFrame_r;
   assign frameDrop = drop_r;
   assign linkBusy = ~oeN_r;
endmodule
`default_nettype wire

//--- hw/ssf_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_host_end
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // serial link
   ssf_link_if.host link,
   // register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready
);
   // ----------------------------------------
   // data input synchroniser
   // ----------------------------------------
   logic [2:0] sdoSync_r;
   logic sdoFilt_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sdoSync_r <= 3'h0;
         sdoFilt_r <= 1'b0;
      end
      else
      begin
         sdoSync_r <= {sdoSync_r[1:0], link.sdoLine};
         if (sdoSync_r[1] == sdoSync_r[2])
         begin
            sdoFilt_r <= sdoSync_r[2];
         end
      end
   end

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   ssf_hstate_t state_r;
   ssf_hstate_t state_nxt;
   logic [TMR_W-1:0] timer_r;
   logic [TMR_W-1:0] timer_nxt;
   logic selN_r;
   logic selN_nxt;
   logic sclk_r;
   logic sclk_nxt;
   logic [CHAIN_BITS-1:0] tx_r;
   logic [CHAIN_BITS-1:0] tx_nxt;
   logic [CHAIN_BITS-1:0] rx_r;
   logic [CHAIN_BITS-1:0] rx_nxt;
   logic [BITCNT_W-1:0] bit_r;
   logic [BITCNT_W-1:0] bit_nxt;
   logic rspValid_r;
   logic rspValid_nxt;
   logic [CHAIN_BITS-1:0] rspWord_r;
   logic [CHAIN_BITS-1:0] rspWord_nxt;
   wire tmrDone;

   assign tmrDone = (timer_r == 8'h00);

   // ----------------------------------------
   // register bus decode
   // ----------------------------------------
   wire idle;
   wire busAcc;
   wire cmdWr;
   wire rspRd;
   wire cmdValid;
   wire [CHAIN_BITS-1:0] cmdWord;
   wire [APB_DW-1:0] statWord;
   wire [APB_DW-1:0] rdMux;
   logic [APB_DW-1:0] prdata_r;
   logic rspNew_r;

   assign idle = (state_r == H_IDLE);
   assign busAcc = psel & penable;
   assign cmdWr = psel & pwrite & (paddr == CMD_OFS);
   assign rspRd = busAcc & ~pwrite & (paddr == RSP_OFS);
   // a command waits in its access phase until the sequencer is idle
   assign pready = ~(cmdWr & ~idle);
   assign cmdValid = busAcc & cmdWr & idle;
   assign cmdWord = pwdata[CHAIN_BITS-1:0];
   assign statWord = APB_DW'({rspNew_r, ~idle});
   assign rdMux = (paddr == RSP_OFS) ? APB_DW'(rspWord_r) : ((paddr == STAT_OFS) ? statWord : BUS_RESET);

   always_comb
   begin
      state_nxt = state_r;
      timer_nxt = tmrDone ? timer_r : timer_r - 8'h01;
      selN_nxt = selN_r;
      sclk_nxt = sclk_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      bit_nxt = bit_r;
      rspValid_nxt = 1'b0;
      rspWord_nxt = rspWord_r;
      case (state_r)
         H_IDLE:
            if (cmdValid)
            begin
               state_nxt = H_LEAD;
               selN_nxt = 1'b0; // R1 R6
               tx_nxt = cmdWord; // R11
               bit_nxt = 8'h00;
               timer_nxt = LEAD_LAST;
            end
         H_LEAD:
            if (tmrDone)
            begin
               state_nxt = H_HIGH;
               sclk_nxt = 1'b1;
               timer_nxt = HALF_LAST;
            end
         H_HIGH:
            if (tmrDone)
            begin
               state_nxt = H_LOW;
               sclk_nxt = 1'b0;
               rx_nxt = {rx_r[CHAIN_BITS-2:0], sdoFilt_r};
               bit_nxt = bit_r + 8'h01;
               timer_nxt = HALF_LAST;
            end
         H_LOW:
            if (tmrDone)
            begin
               if (bit_r == BITS_TOTAL) // R10
               begin
                  state_nxt = H_LAG;
                  timer_nxt = LAG_LAST;
               end
               else
               begin
                  state_nxt = H_HIGH;
                  sclk_nxt = 1'b1;
                  tx_nxt = {tx_r[CHAIN_BITS-2:0], 1'b0};
                  timer_nxt = HALF_LAST;
               end
            end
         H_LAG:
            if (tmrDone)
            begin
               state_nxt = H_GAP;
               selN_nxt = 1'b1; // R6
               rspValid_nxt = 1'b1; // R18
               rspWord_nxt = rx_r;
               timer_nxt = GAP_LAST;
            end
         H_GAP:
            if (tmrDone)
            begin
               state_nxt = H_IDLE;
            end
         default:
            state_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r <= H_IDLE;
         timer_r <= 8'h00;
         selN_r <= 1'b1;
         sclk_r <= 1'b0;
         tx_r <= FRAME_RESET;
         rx_r <= FRAME_RESET;
         bit_r <= 8'h00;
         rspValid_r <= 1'b0;
         rspWord_r <= FRAME_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         selN_r <= selN_nxt;
         sclk_r <= sclk_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         bit_r <= bit_nxt;
         rspValid_r <= rspValid_nxt;
         rspWord_r <= rspWord_nxt;
      end
   end

   assign link.selN = selN_r;
   assign link.sclk = sclk_r;
   assign link.sdi = tx_r[CHAIN_BITS-1];

   // read data and response flag
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prdata_r <= BUS_RESET;
         rspNew_r <= 1'b0;
      end
      else
      begin
         if (psel && !penable)
         begin
            prdata_r <= rdMux;
         end
         rspNew_r <= rspValid_r | (rspNew_r & ~rspRd);
      end
   end

   assign prdata = prdata_r;
endmodule
`default_nettype wire

//--- tb/ssf_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_link_sva
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link
   input wire logic selN,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdoOeN
);
   // ------
   // frame capture
   // ------
   logic selQ_r, sclkQ_r, lastWr_r;
   logic [7:0] cnt_r;
   logic [15:0] rxSdo_r, rxSdi_r;
   logic [2:0] lastPtr_r;
   logic [11:0] lastPay_r;
   wire selRise = !selQ_r && selN;
   wire sclkFall = sclkQ_r && !sclk && !selN;
   wire frameOk = selRise && cnt_r == 8'h10;
   always_ff @(posedge clk)
   begin
      selQ_r <= srst | selN;
      sclkQ_r <= sclk & ~srst;
   end
   always_ff @(posedge clk)
   begin
      if (srst || (selQ_r && !selN))
         cnt_r <= 8'h00;
      else if (sclkFall)
         cnt_r <= cnt_r + 8'h01;
   end
   always_ff @(posedge clk)
   begin
      if (sclkFall)
      begin
         rxSdo_r <= {rxSdo_r[14:0], sdo};
         rxSdi_r <= {rxSdi_r[14:0], sdi};
      end
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lastPtr_r <= SDS_PTR;
         lastWr_r <= 1'b0;
         lastPay_r <= REG_RESET;
      end
      else if (frameOk)
      begin
         lastPtr_r <= rxSdi_r[14:12];
         lastWr_r <= rxSdi_r[15];
         lastPay_r <= rxSdi_r[11:0];
      end
   end
   // ------
   // assertions
   // ------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_float; selN [*8] |-> sdoOeN; endproperty
   a_float: assert property (p_float) else $error("output driven while deselected");
   property p_drive; $fell(selN) |-> ##[3:6] !sdoOeN; endproperty
   a_drive: assert property (p_drive) else $error("output not driven after select fall");
   property p_hold; (!selN && !sclk) [*8] |-> $stable(sdo); endproperty
   a_hold: assert property (p_hold) else $error("output moved with clock low");
   property p_sclk; $rose(sclk) |-> !selN; endproperty
   a_sclk: assert property (p_sclk) else $error("clock pulse while deselected");
   property p_edge; $changed(selN) |-> !sclk && !$past(sclk); endproperty
   a_edge: assert property (p_edge) else $error("select moved with clock high");
   property p_count; selRise |-> cnt_r == 8'h10; endproperty
   a_count: assert property (p_count) else $error("frame not sixteen clocks");
   property p_parity; frameOk |-> (^rxSdo_r) == 1'b0; endproperty
   a_parity: assert property (p_parity) else $error("reply parity wrong");
   property p_echo; frameOk |-> rxSdo_r[14:12] == lastPtr_r; endproperty
   a_echo: assert property (p_echo) else $error("reply pointer wrong");
   property p_wrback; frameOk && lastWr_r && lastPtr_r != SDS_PTR |-> rxSdo_r[11:0] == lastPay_r; endproperty
   a_wrback: assert property (p_wrback) else $error("reply after write wrong");
endmodule
`default_nettype wire

//--- tb/tb_spi_slave_16bit_frame.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_16bit_frame
   import ssf_pkg::*;
   ;
   localparam logic [PAY_W-1:0] DIAG = 12'h435;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, frameDropB, rxValidB;
   logic [15:0] rxFrameB;
   logic [REG_COUNT*PAY_W-1:0] regs, regsB;
   logic [PTR_W-1:0] wrPtr;
   logic [PAY_W-1:0] wrData;
   logic [PAY_W-1:0] model [REG_COUNT];
   int mismatches = 0, checks_done = 0, drops = 0, decodes = 0;
   ssf_link_if iLink();
   ssf_link_if iLinkB();
   ssf_host_end i_ssf_host_end (.clk(clk), .srst(srst), .link(iLink.host), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
   ssf_dev_end i_ssf_dev_end (.clk(clk), .srst(srst), .link(iLink.dev), .diagStatus(DIAG), .regsFlat(regs),
      .wrStrobe(), .wrPtr(wrPtr), .wrData(wrData), .rxValid(), .rxFrame(), .frameDrop(), .linkBusy());
   ssf_dev_end i_ssf_dev_end_b (.clk(clk), .srst(srst), .link(iLinkB.dev), .diagStatus(DIAG), .regsFlat(regsB),
      .wrStrobe(), .wrPtr(), .wrData(), .rxValid(rxValidB), .rxFrame(rxFrameB), .frameDrop(frameDropB),
      .linkBusy());
   ssf_link_sva i_ssf_link_sva (.clk(clk), .srst(srst), .selN(iLink.selN), .sclk(iLink.sclk), .sdi(iLink.sdi),
      .sdo(iLink.sdo), .sdoOeN(iLink.sdoOeN));
   // ------
   // helpers
   // ------
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (frameDropB === 1'b1)
         drops++;
      if (rxValidB === 1'b1)
         decodes++;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] reply(input logic [2:0] p, input logic [11:0] d);
      return {^{p, d}, p, d};
   endfunction
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_ready();
      logic [31:0] q;
      q = 32'hffffffff;
      while (q[BUSY_POS] !== 1'b0)
      begin
         apb(1'b0, STAT_OFS, 32'h00000000, q);
      end
   endtask
   task automatic collect(output logic [15:0] r);
      logic [31:0] q;
      q = 32'h00000000;
      while (q[NEW_POS] !== 1'b1)
      begin
         apb(1'b0, STAT_OFS, 32'h00000000, q);
      end
      apb(1'b0, RSP_OFS, 32'h00000000, q);
      r = q[15:0];
   endtask
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      logic [31:0] q;
      apb(1'b1, CMD_OFS, {16'h0000, w}, q);
      collect(r);
   endtask
   task automatic bang(input logic low, input int nb, input logic [31:0] w, output logic [15:0] cap);
      int i;
      cap = 16'h0000;
      @(posedge clk);
      iLinkB.selN <= ~low;
      repeat (40) @(posedge clk);
      for (i = 0; i < nb; i++)
      begin
         repeat (16) @(posedge clk);
         iLinkB.sclk <= 1'b1;
         iLinkB.sdi <= w[nb - 1 - i];
         repeat (16) @(posedge clk);
         cap = {cap[14:0], iLinkB.sdoLine};
         iLinkB.sclk <= 1'b0;
      end
      repeat (40) @(posedge clk);
      iLinkB.selN <= 1'b1;
      iLinkB.sdi <= ~iLinkB.sdi;
      repeat (40) @(posedge clk);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_frames();
      logic [15:0] r, prev;
      logic [31:0] q;
      logic [11:0] pay;
      int p;
      xfer(16'h2000, r);
      check(r, reply(SDS_PTR, DIAG));
      prev = reply(3'h2, model[2]);
      for (p = 1; p < REG_COUNT; p++)
      begin
         pay = 12'(p * 12'h123) ^ 12'ha5c;
         apb(1'b1, CMD_OFS, {16'h0000, 1'b1, 3'(p), pay}, q);
         check(16'(regs[p*PAY_W +: PAY_W]), 16'(model[p]));
         collect(r);
         check(r, prev);
         wait_ready();
         check(16'(regs[p*PAY_W +: PAY_W]), 16'(pay));
         check({1'b0, wrPtr, wrData}, {1'b0, 3'(p), pay});
         model[p] = pay;
         prev = reply(3'(p), pay);
      end
      for (p = 0; p <= REG_COUNT; p++)
      begin
         xfer({1'b0, 3'(p), 12'hfff}, r);
         check(r, prev);
         prev = reply(3'(p), p % REG_COUNT == 0 ? DIAG : model[p % REG_COUNT]);
      end
      $display("test frames done");
   endtask
   task automatic t_bad();
      logic [15:0] cap, rs;
      int d0, v0;
      d0 = drops;
      v0 = decodes;
      rs = reply(SDS_PTR, DIAG);
      bang(1'b1, 20, 32'hd123, cap);
      bang(1'b1, 0, 32'h0, cap);
      bang(1'b0, 8, 32'hff, cap);
      check(16'(drops - d0), 16'h0002);
      check(16'(decodes - v0), 16'h0000);
      check(16'(regsB[5*PAY_W +: PAY_W]), 16'h0000);
      check({15'h0000, iLinkB.sdoOeN}, 16'h0001);
      bang(1'b1, 8, 32'h0c, cap);
      check(16'(decodes - v0), 16'h0001);
      check(rxFrameB, {rs[7:0], 8'h0c});
      bang(1'b1, 32, 32'h9c3ae5a7, cap);
      check(cap, 16'h9c3a);
      check(rxFrameB, 16'he5a7);
      check(16'(regsB[6*PAY_W +: PAY_W]), 16'h05a7);
      $display("test bad frames done");
   endtask
   // ------
   // run
   // ------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #200000;
      mismatches++;
      print_verdict();
   end
   initial
   begin
      iLinkB.selN = 1'b1;
      iLinkB.sclk = 1'b0;
      iLinkB.sdi = 1'b0;
      foreach (model[i])
         model[i] = REG_RESET;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_frames();
      t_bad();
      print_verdict();
   end
endmodule
`default_nettype wire
